// File: rtl/tpic_top.sv
// Timer array unit: APB registers, prescaler, pin synchronisers and capture channels
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "tpic_defines.svh"
module tpic_top
#(
  parameter int CH_NUM = 8
)
(
  input wire logic CORE_CLK_IN,
  input wire logic NRST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire tpic_pkg::tpic_word_t PWDATA_IN,
  output tpic_pkg::tpic_word_t PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic [7:0] TIMER_INPUT_PIN_IN,
  output logic [7:0] CHANNEL_INTERRUPT_OUT,
  output logic IRQ_OUT
);
  import tpic_pkg::*;

  if (CH_NUM != 8)
  begin : g_bad_ch_num
    $error("tpic_top: the unit has exactly eight channels");
  end

  // Mask of prescaler bits that must be zero for a tick of divide-by-2^sel
  function automatic logic [15:0] presc_mask(input logic [3:0] sel);
    presc_mask = 16'hffff >> (5'h10 - {1'b0, sel});
  endfunction

  // Field of a channel mode word
  function automatic logic [1:0] mode_cks(input logic [15:0] mode);
    mode_cks = mode[`TPIC_MODE_CKS_LSB +: 2];
  endfunction

  // Registers
  logic unit_run_reg;
  logic [15:0] prescale_reg;
  logic [15:0] div_reg;
  logic [7:0] filter_en_reg;
  logic [7:0] int_status_reg;
  logic [7:0] int_mask_reg;
  logic [15:0] mode_reg [8];
  tpic_word_t prdata_reg;
  logic slverr_reg;
  logic [7:0] irq_out_reg;
  logic [7:0] sync_a_reg, sync_b_reg, sync_c_reg, pin_lvl_reg;

  // Next values
  logic [15:0] div_next;
  logic [7:0] int_status_next;
  logic [7:0] pin_lvl_next;
  tpic_word_t rdata_next;

  // Channel results gathered from the generate loop; prescaler tick streams
  logic [7:0] ch_enabled;
  logic [7:0] ch_irq;
  logic [7:0] ch_ovf;
  logic [15:0] ch_count [8];
  logic [15:0] ch_data [8];
  logic [3:0] op_tick;

  // Bus decode
  wire setup_ph = PSEL_IN && !PENABLE_IN;
  wire access_ph = PSEL_IN && PENABLE_IN;
  wire wr_access = access_ph && PWRITE_IN;
  wire wr_allowed = wr_access && unit_run_reg;
  wire word_ok = (PADDR_IN[1:0] == 2'b00);
  wire hit_periph = word_ok && PADDR_IN == `TPIC_OFF_PERIPH_EN;
  wire hit_presc = word_ok && PADDR_IN == `TPIC_OFF_PRESCALE;
  wire hit_start = word_ok && PADDR_IN == `TPIC_OFF_START;
  wire hit_stop = word_ok && PADDR_IN == `TPIC_OFF_STOP;
  wire hit_enstat = word_ok && PADDR_IN == `TPIC_OFF_ENABLE_STAT;
  wire hit_filter = word_ok && PADDR_IN == `TPIC_OFF_FILTER_EN;
  wire hit_intst = word_ok && PADDR_IN == `TPIC_OFF_INT_STATUS;
  wire hit_intmask = word_ok && PADDR_IN == `TPIC_OFF_INT_MASK;
  wire hit_chan = word_ok && PADDR_IN[11:7] == `TPIC_CH_BLOCK_SEL;
  wire [2:0] ch_idx = PADDR_IN[6:4];
  wire [3:0] ch_off = PADDR_IN[3:0];
  wire hit_any = hit_periph || hit_presc || hit_start || hit_stop || hit_enstat ||
                 hit_filter || hit_intst || hit_intmask || hit_chan;
  wire wr_mode = wr_allowed && hit_chan && ch_off == `TPIC_CH_OFF_MODE;

  // Trigger bits exist only as one-cycle pulses, so they read back as zero
  wire [7:0] start_pulse = (wr_allowed && hit_start) ? PWDATA_IN[7:0] : 8'h00;
  wire [7:0] stop_pulse = (wr_allowed && hit_stop) ? PWDATA_IN[7:0] : 8'h00;
  wire [7:0] int_clear = (wr_allowed && hit_intst) ? PWDATA_IN[7:0] : 8'h00;

  // Prescaler: four tick streams at core/2^sel
  assign div_next = unit_run_reg ? div_reg + 16'h0001 : 16'h0000;

  genvar k;
  for (k = 0; k < 4; k++)
  begin : g_presc
    assign op_tick[k] = unit_run_reg &&
      ((div_reg & presc_mask(prescale_reg[k*`TPIC_PRESC_FIELD_W +: `TPIC_PRESC_FIELD_W])) ==
      16'h0000);
  end

  // Pin level moves once the second and third sync stages agree
  assign pin_lvl_next = (sync_b_reg & sync_c_reg) | (pin_lvl_reg & (sync_b_reg | sync_c_reg));

  // Interrupt status: a new event wins over a write-one clear in the same cycle
  assign int_status_next = (int_status_reg & ~int_clear) | ch_irq;

  // Read data selection
  wire [15:0] ch_word =
    (ch_off == `TPIC_CH_OFF_MODE) ? mode_reg[ch_idx] :
    (ch_off == `TPIC_CH_OFF_DATA) ? ch_data[ch_idx] :
    (ch_off == `TPIC_CH_OFF_COUNT) ? ch_count[ch_idx] :
    (ch_off == `TPIC_CH_OFF_STATUS) ? {15'h0000, ch_ovf[ch_idx]} : 16'h0000;

  assign rdata_next =
    hit_periph ? {31'h00000000, unit_run_reg} :
    hit_presc ? {16'h0000, prescale_reg} :
    hit_enstat ? {24'h000000, ch_enabled} :
    hit_filter ? {24'h000000, filter_en_reg} :
    hit_intst ? {24'h000000, int_status_reg} :
    hit_intmask ? {24'h000000, int_mask_reg} :
    hit_chan ? {16'h0000, ch_word} : 32'h00000000;

  // Bus answer is latched in the setup cycle; access completes at once
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      prdata_reg <= 32'h00000000;
      slverr_reg <= 1'b0;
    end
    else if (setup_ph)
    begin
      prdata_reg <= PWRITE_IN ? 32'h00000000 : rdata_next;
      slverr_reg <= !hit_any;
    end
  end

  // Unit enable; clearing it returns every register except the pin synchronisers, irq_out_reg and the bus answer to reset
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
      unit_run_reg <= 1'b0;
    else if (wr_access && hit_periph)
      unit_run_reg <= PWDATA_IN[`TPIC_UNIT_EN_BIT];
  end

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      prescale_reg <= `TPIC_PRESCALE_RESET;
      filter_en_reg <= 8'h00;
      int_mask_reg <= 8'h00;
      div_reg <= 16'h0000;
    end
    else if (!unit_run_reg)
    begin
      prescale_reg <= `TPIC_PRESCALE_RESET;
      filter_en_reg <= 8'h00;
      int_mask_reg <= 8'h00;
      div_reg <= 16'h0000;
    end
    else
    begin
      div_reg <= div_next;
      if (wr_allowed && hit_presc)
        prescale_reg <= PWDATA_IN[15:0];
      if (wr_allowed && hit_filter)
        filter_en_reg <= PWDATA_IN[7:0];
      if (wr_allowed && hit_intmask)
        int_mask_reg <= PWDATA_IN[7:0];
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      int_status_reg <= 8'h00;
      irq_out_reg <= 8'h00;
    end
    else
    begin
      int_status_reg <= unit_run_reg ? int_status_next : 8'h00;
      irq_out_reg <= ch_irq;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      sync_a_reg <= 8'h00;
      sync_b_reg <= 8'h00;
      sync_c_reg <= 8'h00;
      pin_lvl_reg <= 8'h00;
    end
    else
    begin
      sync_a_reg <= TIMER_INPUT_PIN_IN;
      sync_b_reg <= sync_a_reg;
      sync_c_reg <= sync_b_reg;
      pin_lvl_reg <= pin_lvl_next;
    end
  end

  // Eight independent channels
  genvar i;
  for (i = 0; i < CH_NUM; i++)
  begin : g_ch
    tpic_chan_if ch_if ();
    wire [1:0] cks = mode_cks(mode_reg[i]);
    // Only channels 1 and 3 reach the third and fourth prescaled clocks
    wire [1:0] clk_sel = (i == 1 || i == 3) ? cks : {1'b0, cks[0]};

    always_ff @(posedge CORE_CLK_IN or negedge NRST_IN)
    begin
      if (!NRST_IN)
        mode_reg[i] <= `TPIC_MODE_RESET;
      else if (!unit_run_reg)
        mode_reg[i] <= `TPIC_MODE_RESET;
      else if (wr_mode && ch_idx == 3'(i))
        mode_reg[i] <= PWDATA_IN[15:0] & ((i == 1 || i == 3) ? 16'hffff : 16'hdfff);
    end

    assign ch_if.unit_run = unit_run_reg;
    assign ch_if.start_pulse = start_pulse[i];
    assign ch_if.stop_pulse = stop_pulse[i];
    assign ch_if.op_tick = op_tick[clk_sel];
    assign ch_if.pin_level = pin_lvl_reg[i];
    assign ch_if.filter_en = filter_en_reg[i];
    assign ch_if.start_int_mode = mode_reg[i][`TPIC_MODE_START_INT_BIT];
    assign ch_if.trig_sel = mode_reg[i][`TPIC_MODE_TRIG_LSB +: 3];
    assign ch_if.edge_sel = mode_reg[i][`TPIC_MODE_EDGE_LSB +: 2];

    assign ch_enabled[i] = ch_if.enabled;
    assign ch_irq[i] = ch_if.irq;
    assign ch_ovf[i] = ch_if.ovf;
    assign ch_count[i] = ch_if.count;
    assign ch_data[i] = ch_if.data;

    tpic_channel u_chan
    (
      .clk_in(CORE_CLK_IN),
      .nrst_in(NRST_IN),
      .ch(ch_if.chan)
    );
  end

  assign PRDATA_OUT = prdata_reg;
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = slverr_reg && access_ph;
  assign CHANNEL_INTERRUPT_OUT = irq_out_reg;
  assign IRQ_OUT = |(int_status_reg & int_mask_reg);
endmodule
`default_nettype wire

// File: rtl/tpic_defines.svh
// Register offsets, field positions, reset values and widths of the pulse interval timer
`ifndef TPIC_DEFINES_SVH
`define TPIC_DEFINES_SVH
`define TPIC_ADDR_W 12
`define TPIC_CNT_W 16
`define TPIC_CNT_MAX 16'hffff
`define TPIC_OFF_PERIPH_EN 12'h000
`define TPIC_OFF_PRESCALE 12'h004
`define TPIC_OFF_START 12'h008
`define TPIC_OFF_STOP 12'h00c
`define TPIC_OFF_ENABLE_STAT 12'h010
`define TPIC_OFF_FILTER_EN 12'h014
`define TPIC_OFF_INT_STATUS 12'h018
`define TPIC_OFF_INT_MASK 12'h01c
`define TPIC_CH_BLOCK_SEL 5'h01
`define TPIC_CH_OFF_MODE 4'h0
`define TPIC_CH_OFF_DATA 4'h4
`define TPIC_CH_OFF_COUNT 4'h8
`define TPIC_CH_OFF_STATUS 4'hc
`define TPIC_UNIT_EN_BIT 0
`define TPIC_PRESC_FIELD_W 4
`define TPIC_MODE_W 16
`define TPIC_MODE_RESET 16'h0000
`define TPIC_MODE_START_INT_BIT 0
`define TPIC_MODE_EDGE_LSB 1
`define TPIC_MODE_TRIG_LSB 4
`define TPIC_MODE_OUT_MODE_BIT 8
`define TPIC_MODE_OUT_LEVEL_BIT 9
`define TPIC_MODE_CKS_LSB 12
`define TPIC_TRIG_SEL_EDGE 3'h1
`define TPIC_EDGE_FALL 2'h0
`define TPIC_EDGE_RISE 2'h1
`define TPIC_STATUS_OVF_BIT 0
`define TPIC_PRESCALE_RESET 16'h0000
`endif

// File: rtl/tpic_pkg.sv
// Types shared by the pulse interval timer modules
package tpic_pkg;
  typedef logic [31:0] tpic_word_t;
  typedef logic [15:0] tpic_count_t;
  typedef enum logic [1:0] {CH_STOPPED, CH_WAIT_CLEAR, CH_RUNNING} tpic_state_t;
endpackage

// File: rtl/tpic_chan_if.sv
// Signals between the unit control logic and one measurement channel
`timescale 1ns/1ps
`default_nettype none
interface tpic_chan_if;
  logic unit_run;
  logic start_pulse;
  logic stop_pulse;
  logic op_tick;
  logic pin_level;
  logic filter_en;
  logic start_int_mode;
  logic [2:0] trig_sel;
  logic [1:0] edge_sel;
  logic enabled;
  logic irq;
  logic ovf;
  logic [15:0] count;
  logic [15:0] data;
  modport top(output unit_run, start_pulse, stop_pulse, op_tick, pin_level, filter_en,
    start_int_mode, trig_sel, edge_sel, input enabled, irq, ovf, count, data);
  modport chan(input unit_run, start_pulse, stop_pulse, op_tick, pin_level, filter_en,
    start_int_mode, trig_sel, edge_sel, output enabled, irq, ovf, count, data);
endinterface
`default_nettype wire

// File: rtl/tpic_channel.sv
// One capture channel: up counter, edge capture, overflow tracking
`timescale 1ns/1ps
`default_nettype none
`include "tpic_defines.svh"
module tpic_channel
(
  input wire logic clk_in,
  input wire logic nrst_in,
  tpic_chan_if.chan ch
);
  import tpic_pkg::*;

  tpic_state_t state_reg, state_next;
  tpic_count_t count_reg, count_next, data_reg;
  logic ovf_reg, wrap_reg, irq_reg, samp_reg, lvl_reg, lvl_prev_reg;

  wire running = (state_reg != CH_STOPPED);
  // Filter keeps the level until two operating-clock samples agree
  wire lvl_next = (!ch.filter_en || samp_reg == ch.pin_level) ? ch.pin_level : lvl_reg;
  wire rise = lvl_reg & ~lvl_prev_reg;
  wire fall = ~lvl_reg & lvl_prev_reg;
  wire edge_ok = (ch.edge_sel == `TPIC_EDGE_RISE) ? rise :
                 (ch.edge_sel == `TPIC_EDGE_FALL) ? fall : (rise | fall);
  wire edge_hit = ch.op_tick && running && edge_ok && ch.trig_sel == `TPIC_TRIG_SEL_EDGE;
  wire sw_capture = ch.start_pulse && running;
  wire capture = edge_hit || sw_capture;
  wire starting = ch.start_pulse && !running;
  wire wrap_now = ch.op_tick && state_reg == CH_RUNNING && count_reg == `TPIC_CNT_MAX;

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      CH_STOPPED:
        if (starting)
          state_next = CH_WAIT_CLEAR;
      CH_WAIT_CLEAR:
        if (ch.stop_pulse)
          state_next = CH_STOPPED;
        else if (ch.op_tick || capture)
          state_next = CH_RUNNING;
      CH_RUNNING:
        if (ch.stop_pulse)
          state_next = CH_STOPPED;
    endcase
  end

  // Stop freezes the count; capture or a count clock in CH_WAIT_CLEAR clears it; otherwise count up per count clock in CH_RUNNING
  always_comb
  begin
    count_next = count_reg;
    if (ch.stop_pulse)
      count_next = count_reg;
    else if (capture)
      count_next = '0;
    else if (ch.op_tick && state_reg == CH_WAIT_CLEAR)
      count_next = '0;
    else if (ch.op_tick && state_reg == CH_RUNNING)
      count_next = count_reg + 16'h0001;
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state_reg <= CH_STOPPED;
      count_reg <= '0;
      data_reg <= '0;
      ovf_reg <= 1'b0;
      wrap_reg <= 1'b0;
      irq_reg <= 1'b0;
      samp_reg <= 1'b0;
      lvl_reg <= 1'b0;
      lvl_prev_reg <= 1'b0;
    end
    else if (!ch.unit_run)
    begin
      state_reg <= CH_STOPPED;
      count_reg <= '0;
      data_reg <= '0;
      ovf_reg <= 1'b0;
      wrap_reg <= 1'b0;
      irq_reg <= 1'b0;
      samp_reg <= 1'b0;
      lvl_reg <= 1'b0;
      lvl_prev_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      count_reg <= count_next;
      irq_reg <= capture || (starting && ch.start_int_mode);
      if (capture)
      begin
        data_reg <= count_reg;
        ovf_reg <= wrap_reg;
        wrap_reg <= 1'b0;
      end
      else if (wrap_now)
        wrap_reg <= 1'b1;
      if (ch.op_tick)
      begin
        samp_reg <= ch.pin_level;
        lvl_reg <= lvl_next;
        lvl_prev_reg <= lvl_reg;
      end
    end
  end

  assign ch.enabled = running;
  assign ch.irq = irq_reg;
  assign ch.ovf = ovf_reg;
  assign ch.count = count_reg;
  assign ch.data = data_reg;
endmodule
`default_nettype wire

// File: bench/tpic_top_assertions.sv
// Port-level checker for the pulse interval timer top module
`timescale 1ns/1ps
`default_nettype none
module tpic_top_assertions
#(
  parameter int CH_NUM = 8
)
(
  input wire logic CORE_CLK_IN,
  input wire logic NRST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire tpic_pkg::tpic_word_t PWDATA_IN,
  input wire tpic_pkg::tpic_word_t PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire logic [7:0] TIMER_INPUT_PIN_IN,
  input wire logic [7:0] CHANNEL_INTERRUPT_OUT,
  input wire logic IRQ_OUT
);
  import tpic_pkg::*;
  wire rd_setup = PSEL_IN && !PENABLE_IN && !PWRITE_IN;
  wire wr_done = PSEL_IN && PENABLE_IN && PWRITE_IN;
  default clocking @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (!NRST_IN);
  ready_always_a: assert property (PREADY_OUT) else $error("ready low");
  err_access_only_a: assert property (!(PSEL_IN && PENABLE_IN) |-> !PSLVERR_OUT)
    else $error("error outside access");
  unmapped_err_a: assert property (rd_setup && PADDR_IN == 12'h020 |=> PSLVERR_OUT)
    else $error("no error on unmapped read");
  start_reads_zero_a: assert property (
    rd_setup && PADDR_IN == 12'h008 |=> PRDATA_OUT == 32'h0) else $error("start reads nonzero");
  stop_reads_zero_a: assert property (
    rd_setup && PADDR_IN == 12'h00c |=> PRDATA_OUT == 32'h0) else $error("stop reads nonzero");
  irq_single_a: assert property (
    |CHANNEL_INTERRUPT_OUT |=> (CHANNEL_INTERRUPT_OUT & $past(CHANNEL_INTERRUPT_OUT)) == 8'h00)
    else $error("interrupt longer than a cycle");
  disable_quiet_a: assert property (
    wr_done && PADDR_IN == 12'h000 && !PWDATA_IN[0] |-> ##2 !IRQ_OUT) else $error("irq after disable");
  mask_quiet_a: assert property (wr_done && PADDR_IN == 12'h01c && PWDATA_IN == 32'h0 |=> !IRQ_OUT)
    else $error("irq with mask clear");
  ovf_field_a: assert property (
    rd_setup && PADDR_IN[11:7] == 5'h01 && PADDR_IN[3:0] == 4'hc |=> PRDATA_OUT[31:1] == 31'h0)
    else $error("status upper bits set");
  enable_field_a: assert property (
    rd_setup && PADDR_IN == 12'h010 |=> PRDATA_OUT[31:8] == 24'h0) else $error("enable bits wide");
endmodule
bind tpic_top tpic_top_assertions #(.CH_NUM(CH_NUM)) u_chk (.CORE_CLK_IN(CORE_CLK_IN),
  .NRST_IN(NRST_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN),
  .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
  .PSLVERR_OUT(PSLVERR_OUT), .TIMER_INPUT_PIN_IN(TIMER_INPUT_PIN_IN),
  .CHANNEL_INTERRUPT_OUT(CHANNEL_INTERRUPT_OUT), .IRQ_OUT(IRQ_OUT));
`default_nettype wire

// File: bench/tpic_pulse_src.sv
// External pulse source driving the timer input pins
`timescale 1ns/1ps
`default_nettype none
module tpic_pulse_src
(
  input wire logic clk_in,
  output logic [7:0] pin_out
);
  initial pin_out = 8'h00;
  // Rising edges spaced period cycles; pulses stay well above the two-cycle minimum
  task automatic train(input int n, input int period, input int cnt);
    repeat (cnt)
    begin
      @(posedge clk_in);
      pin_out[n] <= 1'b1;
      repeat (period / 2) @(posedge clk_in);
      pin_out[n] <= 1'b0;
      repeat (period - period / 2 - 1) @(posedge clk_in);
    end
  endtask
endmodule
`default_nettype wire

// File: bench/test_timer_pulse_interval_capture.sv
// Register-level test of the pulse interval timer
`timescale 1ns/1ps
`default_nettype none
module test_timer_pulse_interval_capture;
  import tpic_pkg::*;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [11:0] paddr;
  logic [7:0] pins, ch_irq;
  tpic_word_t pwdata, prdata, rd, c;
  int failures, tests_run, s;
  tpic_top #(.CH_NUM(8)) dut (.CORE_CLK_IN(clk), .NRST_IN(nrst), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .TIMER_INPUT_PIN_IN(pins), .CHANNEL_INTERRUPT_OUT(ch_irq), .IRQ_OUT(irq));
  tpic_pulse_src src (.clk_in(clk), .pin_out(pins));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task complete_run;
    if (failures == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task check(input tpic_word_t got, input tpic_word_t exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; held until ready is seen at a rising edge
  task xfer(input logic [11:0] a, input logic w, input tpic_word_t d);
    int i;
    i = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Request stands until ready is sampled high at a rising edge
    @(posedge clk);
    while (pready !== 1'b1 && i < 20)
    begin
      @(posedge clk);
      i++;
    end
    if (i == 20)
    begin
      failures++;
      complete_run;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd_chk(input logic [11:0] a, input tpic_word_t exp);
    xfer(a, 1'b0, 32'h0);
    check(rd, exp);
  endtask
  task wait_irq(input int n);
    int i;
    i = 0;
    @(negedge clk);
    while (ch_irq[n] !== 1'b1 && i < 200)
    begin
      @(negedge clk);
      i++;
    end
    if (i == 200)
    begin
      failures++;
      complete_run;
    end
  endtask
  initial
  begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    failures = 0;
    tests_run = 0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    rd_chk(12'h000, 32'h0);
    xfer(12'h01c, 1'b1, 32'hff);
    rd_chk(12'h01c, 32'h0);
    xfer(12'h020, 1'b0, 32'h0);
    check({31'h0, err}, 32'h1);
    xfer(12'h000, 1'b1, 32'h1);
    rd_chk(12'h010, 32'h0);
    xfer(12'h01c, 1'b1, 32'hff);
    // Rising edge, start trigger 001, master output mode, level zero, both clock bits
    for (s = 0; s < 8; s++)
    begin
      xfer(12'(12'h080 + s * 16), 1'b1, 32'h3012);
      rd_chk(12'(12'h080 + s * 16), (s == 1 || s == 3) ? 32'h3012 : 32'h1012);
    end
    xfer(12'h008, 1'b1, 32'h1);
    rd_chk(12'h008, 32'h0);
    rd_chk(12'h010, 32'h1);
    xfer(12'h088, 1'b0, 32'h0);
    c = rd;
    xfer(12'h088, 1'b0, 32'h0);
    check({31'h0, rd > c}, 32'h1);
    fork
      src.train(0, 100, 4);
      begin
        wait_irq(0);
        repeat (3)
        begin
          wait_irq(0);
          xfer(12'h084, 1'b0, 32'h0);
          check({31'h0, rd >= 98 && rd <= 100}, 32'h1);
          rd_chk(12'h08c, 32'h0);
        end
      end
    join
    rd_chk(12'h018, 32'h1);
    check({31'h0, irq}, 32'h1);
    xfer(12'h018, 1'b1, 32'h1);
    rd_chk(12'h018, 32'h0);
    check({31'h0, irq}, 32'h0);
    xfer(12'h008, 1'b1, 32'h1);
    repeat (66000) @(posedge clk);
    xfer(12'h008, 1'b1, 32'h1);
    xfer(12'h084, 1'b0, 32'h0);
    check({31'h0, rd >= 464 && rd <= 467}, 32'h1);
    rd_chk(12'h08c, 32'h1);
    xfer(12'h00c, 1'b1, 32'h1);
    rd_chk(12'h00c, 32'h0);
    rd_chk(12'h010, 32'h0);
    xfer(12'h088, 1'b0, 32'h0);
    c = rd;
    repeat (20) @(posedge clk);
    rd_chk(12'h088, c);
    rd_chk(12'h08c, 32'h1);
    xfer(12'h014, 1'b1, 32'h2);
    rd_chk(12'h014, 32'h2);
    xfer(12'h0a0, 1'b1, 32'h0011);
    xfer(12'h008, 1'b1, 32'h4);
    wait_irq(2);
    check({31'h0, irq}, 32'h1);
    xfer(12'h000, 1'b1, 32'h0);
    rd_chk(12'h01c, 32'h0);
    rd_chk(12'h010, 32'h0);
    complete_run;
  end
endmodule
`default_nettype wire
